// [verilog/tkpps_pkg.sv]
// Package with constants and types for the pulse-disciplined time keeper.
package tkpps_pkg;
	// Base clock and the length of one nominal second in base clock cycles.
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam logic [31:0] NOMINAL_PERIOD = 32'h05F5E100;
	// Late-pulse tolerance in microseconds and its cycle count.
	localparam int unsigned LATE_US = 50;
	localparam logic [31:0] LATE_CYC = 32'(LATE_US * (CLK_HZ / 1_000_000));
	// Propagation delay step in nanoseconds; one step is one base clock cycle.
	localparam int unsigned PROP_STEP_NS = 10;
	localparam int unsigned PROP_STEP_CYC = (PROP_STEP_NS * CLK_HZ) / 1_000_000_000;
	// Cycles per microsecond.
	localparam logic [6:0] US_CYC = 7'(CLK_HZ / 1_000_000);
	// Calendar limits.
	localparam logic [16:0] SECS_PER_DAY = 17'h15180;
	localparam logic [8:0] DAYS_NORMAL = 9'h16D;
	localparam logic [8:0] DAYS_LEAP = 9'h16E;
	localparam logic [19:0] US_PER_SEC = 20'hF4240;
	localparam logic [11:0] YEAR_RESET = 12'h7D0;
	// Averaging depth (shift) for the measured period.
	localparam int unsigned AVG_SHIFT = 3;
	// Pulse source encodings.
	typedef enum logic [3:0] {
		pps_src_internal = 4'h0,
		pps_src_decoded_code = 4'h1,
		pps_src_satellite = 4'h2,
		pps_src_ttl_line = 4'h3,
		pps_src_rf_input = 4'h4,
		pps_src_sync_line = 4'h5,
		keeper_off = 4'hF
	} tkpps_src_t;
	// Status vector bit positions.
	localparam int ST_BIN_TO_DEC_ERR = 0;
	localparam int ST_DEC_TO_BIN_ERR = 1;
	localparam int ST_CODE_MISMATCH = 2;
	localparam int ST_PULSE_GENERATED = 3;
	localparam int ST_PULSE_RECEIVED = 4;
	localparam int ST_CODE_APPLIED = 5;
	localparam int ST_ADAPTIVE_PULSE_OK = 6;
	localparam int ST_PULSE_LOST = 7;
	localparam int ST_AVG_PERIOD_BAD = 8;
	localparam int ST_LAST_PULSE_BAD = 9;
	localparam int ST_WIDTH = 10;
	// Period measurement acceptance band around the nominal second.
	localparam logic [31:0] PERIOD_TOL = 32'h000186A0;
endpackage : tkpps_pkg

// [verilog/tkpps_sync.sv]
// Two-flip-flop synchroniser bank with rising edge detection.
module tkpps_sync #(
	parameter int WIDTH = 10
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Asynchronous inputs and their synchronised edges.
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] stage1; // First stage, read only by the second.
	logic [WIDTH-1:0] stage2; // Second stage, safe to use.
	logic [WIDTH-1:0] stage3; // Delayed copy for edge detection.

	// Each line gets its own chain; a metastable first stage never fans out.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_line
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					stage1[g] <= 1'b0;
					stage2[g] <= 1'b0;
					stage3[g] <= 1'b0;
				end else begin
					stage1[g] <= async_i[g];
					stage2[g] <= stage1[g];
					stage3[g] <= stage2[g];
				end
			end
			assign rise_o[g] = stage2[g] & ~stage3[g];
		end
	endgenerate
endmodule // tkpps_sync

// [verilog/tkpps_keeper.sv]
// Top of the pulse-disciplined time keeper.

module tkpps_keeper #(
	parameter logic [31:0] NOMINAL = tkpps_pkg::NOMINAL_PERIOD,
	parameter logic [15:0] PROP_MAX = 16'hFFFF
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Asynchronous pulse inputs.
	input wire logic sat_pps_i,
	input wire logic [3:0] ttl_pps_i,
	input wire logic rf_pps_i,
	input wire logic [3:0] sync_pps_i,
	// Configuration.
	input wire logic [3:0] pps_mode_i,
	input wire logic [1:0] pps_line_i,
	input wire logic fallback_internal_i,
	input wire logic use_fixed_period_i,
	input wire logic slow_timebase_i,
	input wire logic use_binary_seconds_i,
	input wire logic ignore_code_seconds_i,
	input wire logic ignore_code_minutes_i,
	input wire logic ignore_code_days_i,
	input wire logic signed [5:0] offset_hours_i,
	input wire logic signed [6:0] offset_minutes_i,
	input wire logic [15:0] prop_delay_i,
	// Decoded code from the decoder, same clock.
	input wire logic code_valid_i,
	input wire logic code_pps_i,
	input wire logic code_decoding_i,
	input wire logic [16:0] code_sbs_i,
	input wire logic [5:0] code_sec_i,
	input wire logic [5:0] code_min_i,
	input wire logic [4:0] code_hour_i,
	input wire logic [8:0] code_yday_i,
	input wire logic [11:0] code_year_i,
	input wire logic code_bcd_err_i,
	input wire logic code_bin_err_i,
	// Time write.
	input wire logic set_i,
	input wire logic set_secs_valid_i,
	input wire logic set_yday_valid_i,
	input wire logic set_year_valid_i,
	input wire logic [16:0] set_secs_i,
	input wire logic [8:0] set_yday_i,
	input wire logic [11:0] set_year_i,
	// Time read and raw read.
	input wire logic read_i,
	input wire logic raw_read_i,
	output logic [16:0] rd_secs_o,
	output logic [19:0] rd_us_o,
	output logic [8:0] rd_yday_o,
	output logic [11:0] rd_year_o,
	output logic [tkpps_pkg::ST_WIDTH-1:0] rd_status_o,
	output logic rd_valid_o,
	output logic raw_refused_o,
	// Live pulse output.
	output logic pps_o
);
	initial begin
		// The internal second ends at period minus one, so a period needs at least two cycles.
		if (PROP_MAX == 16'h0000 || NOMINAL < 32'h00000002) $error("bad keeper parameters");
	end

	logic [9:0] rise; // Synchronised rising edges of external pulse lines.
	logic ext_edge; // Selected external edge.
	logic [31:0] since; // Cycles since the last second boundary.
	logic [31:0] period; // Active period.
	logic [34:0] avg_acc; // Averaging accumulator.
	logic [31:0] last_gap; // Spacing of last external pulses.
	logic [31:0] gap_cnt; // Cycles between external pulses.
	logic avg_valid; // Averaged period primed.
	logic lost; // External pulse declared missing.
	logic last_bad; // Last pulse outside band.
	logic [15:0] delay_cnt; // Propagation delay countdown.
	logic delay_run; // Delay in progress.
	logic tick; // Second boundary.
	logic gen_tick; // Internally generated second.
	logic [6:0] us_div; // Microsecond prescaler.
	logic [19:0] us; // Microseconds within second.
	logic [16:0] secs; // UTC seconds of day.
	logic [8:0] yday; // Day of year, 1-based.
	logic [11:0] year; // Year.
	logic [tkpps_pkg::ST_WIDTH-1:0] sticky; // Sticky flags.
	logic [tkpps_pkg::ST_WIDTH-1:0] set_ev; // Event sets this cycle.
	logic signed [17:0] off_s; // Offset in seconds.
	logic code_src; // Code is the selected source.
	logic [16:0] code_secs; // Seconds of day from code.
	logic [16:0] next_secs; // Incremented seconds.
	logic [8:0] days_in_year; // Length of current year.

	tkpps_sync #(.WIDTH(10)) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({sat_pps_i, sync_pps_i, rf_pps_i, ttl_pps_i}),
		.rise_o(rise)
	);

	// Source selection; code pulse is already on this clock.
	always_comb begin
		ext_edge = 1'b0;
		code_src = 1'b0;
		unique case (pps_mode_i)
			tkpps_pkg::pps_src_decoded_code: begin
				ext_edge = code_pps_i;
				code_src = 1'b1;
			end
			tkpps_pkg::pps_src_satellite: ext_edge = rise[9];
			tkpps_pkg::pps_src_ttl_line: ext_edge = rise[pps_line_i];
			tkpps_pkg::pps_src_rf_input: ext_edge = rise[4];
			tkpps_pkg::pps_src_sync_line: ext_edge = rise[5 + pps_line_i];
			default: ext_edge = 1'b0;
		endcase
	end

	wire off_mode = (pps_mode_i == tkpps_pkg::keeper_off);
	wire int_mode = (pps_mode_i == tkpps_pkg::pps_src_internal);
	// Slow sources have no expectation window, so they are never declared lost.
	wire late = ~int_mode & ~slow_timebase_i & (since > period + tkpps_pkg::LATE_CYC);

	// Period selection: fixed or averaged measurement when it is primed.
	assign period = (use_fixed_period_i | ~avg_valid) ? NOMINAL : avg_acc[34:3];

	// Measure spacing of valid external pulses and average them.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gap_cnt <= 32'h00000000;
			avg_acc <= 35'h000000000;
			avg_valid <= 1'b0;
			last_gap <= 32'h00000000;
			last_bad <= 1'b0;
		end else if (ext_edge) begin
			gap_cnt <= 32'h00000001;
			last_gap <= gap_cnt;
			last_bad <= (gap_cnt > NOMINAL + tkpps_pkg::PERIOD_TOL) || (gap_cnt < NOMINAL - tkpps_pkg::PERIOD_TOL);
			if ((gap_cnt <= NOMINAL + tkpps_pkg::PERIOD_TOL) && (gap_cnt >= NOMINAL - tkpps_pkg::PERIOD_TOL)) begin
				// Running mean with weight 1/8 keeps the hardware to an adder and shift.
				avg_acc <= avg_valid ? (avg_acc - {3'h0, avg_acc[34:3]} + {3'h0, gap_cnt}) : {gap_cnt, 3'h0};
				avg_valid <= 1'b1;
			end
		end else if (gap_cnt != 32'hFFFFFFFF) begin
			gap_cnt <= gap_cnt + 32'h00000001;
		end
	end

	// Lost detection: set when late, cleared by the next external pulse.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lost <= 1'b0;
		end else if (ext_edge) begin
			lost <= 1'b0;
		end else if (late) begin
			lost <= 1'b1;
		end
	end

	// Propagation delay: accepted edge is delayed by N cycles of 10 ns.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			delay_cnt <= 16'h0000;
			delay_run <= 1'b0;
		end else if (ext_edge && !int_mode && prop_delay_i != 16'h0000) begin
			delay_cnt <= prop_delay_i;
			delay_run <= 1'b1;
		end else if (delay_run) begin
			delay_cnt <= delay_cnt - 16'h0001;
			delay_run <= (delay_cnt != 16'h0001);
		end
	end
	wire ext_tick = (prop_delay_i == 16'h0000) ? ext_edge : (delay_run && delay_cnt == 16'h0001);

	// Internal generation whenever internal mode, or fallback after loss.
	assign gen_tick = (since >= period - 32'h00000001) & (int_mode | (fallback_internal_i & lost));
	assign tick = ~off_mode & ((ext_tick & ~int_mode) | gen_tick);

	// Cycle and microsecond counters restart on each second boundary.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			since <= 32'h00000000;
			us_div <= 7'h00;
			us <= 20'h00000;
		end else if (off_mode || tick) begin
			since <= 32'h00000000;
			us_div <= 7'h00;
			us <= 20'h00000;
		end else begin
			if (since != 32'hFFFFFFFF) since <= since + 32'h00000001;
			if (us_div == tkpps_pkg::US_CYC - 7'h01) begin
				us_div <= 7'h00;
				if (us != tkpps_pkg::US_PER_SEC - 20'h00001) us <= us + 20'h00001;
			end else begin
				us_div <= us_div + 7'h01;
			end
		end
	end

	// Leap year and local offset.
	assign days_in_year = (year[1:0] == 2'b00) ? tkpps_pkg::DAYS_LEAP : tkpps_pkg::DAYS_NORMAL;
	assign off_s = 18'(offset_hours_i) * 18'sd3600 + 18'(offset_minutes_i) * 18'sd60;
	assign next_secs = secs + 17'h00001;

	// Seconds of day from the code: binary field or decimal fields; ignored seconds are held, ignoring minutes keeps the current hour with minutes zeroed.
	always_comb begin
		code_secs = use_binary_seconds_i ? code_sbs_i :
			17'(code_hour_i) * 17'd3600 + 17'(code_min_i) * 17'd60 + 17'(code_sec_i);
		if (ignore_code_minutes_i) code_secs = 17'(secs - secs % 17'd3600 + (use_binary_seconds_i ? code_sbs_i % 17'd60 : 17'(code_sec_i)));
		if (ignore_code_seconds_i) code_secs = 17'(code_secs - code_secs % 17'd60 + secs % 17'd60);
	end

	wire code_take = code_valid_i & code_src;
	wire signed [18:0] set_local = $signed({2'b00, set_secs_i}) - 19'(off_s);
	wire [16:0] set_utc = (set_local < 0) ? 17'(set_local + 19'(tkpps_pkg::SECS_PER_DAY)) :
		(set_local >= 19'(tkpps_pkg::SECS_PER_DAY)) ? 17'(set_local - 19'(tkpps_pkg::SECS_PER_DAY)) : 17'(set_local);

	// Time registers: write, code apply, second advance with rollover.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			secs <= 17'h00000;
			yday <= 9'h001;
			year <= tkpps_pkg::YEAR_RESET;
		end else if (set_i) begin
			if (set_secs_valid_i) secs <= set_utc;
			if (set_yday_valid_i) yday <= set_yday_i;
			if (set_year_valid_i) year <= set_year_i;
		end else if (code_take) begin
			secs <= code_secs;
			if (!ignore_code_days_i) begin
				yday <= code_yday_i;
				year <= code_year_i;
			end
		end else if (tick) begin
			if (next_secs == tkpps_pkg::SECS_PER_DAY) begin
				secs <= 17'h00000;
				if (yday == days_in_year) begin
					yday <= 9'h001;
					year <= year + 12'h001;
				end else begin
					yday <= yday + 9'h001;
				end
			end else begin
				secs <= next_secs;
			end
		end
	end

	// Event sets; live flags are not sticky.
	always_comb begin
		set_ev = '0;
		set_ev[tkpps_pkg::ST_BIN_TO_DEC_ERR] = code_take & code_bin_err_i;
		set_ev[tkpps_pkg::ST_DEC_TO_BIN_ERR] = code_take & code_bcd_err_i;
		set_ev[tkpps_pkg::ST_CODE_MISMATCH] = code_take & ((code_secs != secs) | 1'b1);
		set_ev[tkpps_pkg::ST_PULSE_GENERATED] = gen_tick & ~off_mode;
		set_ev[tkpps_pkg::ST_PULSE_RECEIVED] = ext_edge;
		set_ev[tkpps_pkg::ST_CODE_APPLIED] = code_take;
	end

	// Sticky flags: a set in the read cycle survives the clear.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sticky <= '0;
		end else begin
			sticky <= (read_i ? '0 : sticky) | set_ev;
		end
	end

	// Latch all fields together on a read, local offset applied.
	wire signed [18:0] loc = $signed({2'b00, secs}) + 19'(off_s);
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_secs_o <= 17'h00000;
			rd_us_o <= 20'h00000;
			rd_yday_o <= 9'h000;
			rd_year_o <= 12'h000;
			rd_status_o <= '0;
			rd_valid_o <= 1'b0;
			raw_refused_o <= 1'b0;
		end else begin
			rd_valid_o <= read_i | (raw_read_i & ~code_decoding_i);
			raw_refused_o <= raw_read_i & code_decoding_i;
			if (read_i) begin
				rd_secs_o <= (loc < 0) ? 17'(loc + 19'(tkpps_pkg::SECS_PER_DAY)) :
					(loc >= 19'(tkpps_pkg::SECS_PER_DAY)) ? 17'(loc - 19'(tkpps_pkg::SECS_PER_DAY)) : 17'(loc);
				rd_us_o <= us;
				rd_yday_o <= yday;
				rd_year_o <= year;
				rd_status_o <= {last_bad, ~avg_valid & ~use_fixed_period_i, lost, ~lost & ~off_mode, sticky[5:0]};
			end else if (raw_read_i && !code_decoding_i) begin
				// Raw path hands back decoder contents, no offset.
				rd_secs_o <= code_sbs_i;
				rd_us_o <= 20'h00000;
				rd_yday_o <= code_yday_i;
				rd_year_o <= code_year_i;
			end
		end
	end

	// Pulse output.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) pps_o <= 1'b0;
		else pps_o <= tick;
	end
endmodule // tkpps_keeper

// [bench/tkpps_pulse_src.sv]
// Model of an external once-per-second source that feeds the keeper.
module tkpps_pulse_src #(
	parameter int unsigned PERIOD = 1000
) (
	// Clock of the model.
	input wire logic clk_i,
	// The source runs while this is high.
	input wire logic run_i,
	// Pulse line towards the keeper.
	output logic pulse_o,
	// One-cycle strobe at the start of each second, as the decoder hands it over on the keeper's clock.
	output logic strobe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Position within the current second.
	int unsigned pos;
	// A four-cycle pulse is wide enough for a two-stage synchroniser; a stopped source rests low.
	always @(posedge clk_i) begin
		if (!run_i) begin
			pos <= 0;
			pulse_o <= 1'b0;
			strobe_o <= 1'b0;
		end else begin
			pos <= (pos == PERIOD - 1) ? 0 : pos + 1;
			pulse_o <= (pos < 4);
			strobe_o <= (pos == 0);
		end
	end
endmodule // tkpps_pulse_src

// [bench/tkpps_keeper_assertions.sv]
// Checker of the keeper's behaviour at its ports.
module tkpps_keeper_assertions #(
	parameter logic [31:0] NOMINAL = 32'h05F5E100
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Watched inputs.
	input wire logic [3:0] pps_mode_i,
	input wire logic fallback_internal_i,
	input wire logic use_fixed_period_i,
	input wire logic set_i,
	input wire logic read_i,
	input wire logic raw_read_i,
	input wire logic code_decoding_i,
	// Watched outputs.
	input wire logic [16:0] rd_secs_o,
	input wire logic [11:0] rd_year_o,
	input wire logic rd_valid_o,
	input wire logic raw_refused_o,
	input wire logic pps_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Cycles since the last tick and the mode one cycle ago.
	logic [31:0] gap;
	logic [3:0] mode_q;
	// High once a tick has been seen under unchanged settings.
	logic steady;
	// Counts from one at each tick.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gap <= 32'h0;
			mode_q <= 4'h0;
		end else begin
			gap <= pps_o ? 32'h1 : gap + 32'h1;
			mode_q <= pps_mode_i;
		end
	end
	// A mode change or a time write may restart the second, so judging waits for the next tick.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			steady <= 1'b0;
		end else if (pps_mode_i != mode_q || set_i) begin
			steady <= 1'b0;
		end else if (pps_o) begin
			steady <= 1'b1;
		end
	end
	wire logic base = steady && pps_mode_i == mode_q && use_fixed_period_i;
	chk_read_answer: assert property (read_i |=> rd_valid_o)
		else $error("read not answered");
	chk_valid_cause: assert property (rd_valid_o |-> $past(read_i) || $past(raw_read_i))
		else $error("answer without a read");
	chk_result_stands: assert property (!read_i && !raw_read_i |=> $stable(rd_secs_o) && $stable(rd_year_o))
		else $error("read result changed without a read");
	chk_raw_refused: assert property (raw_read_i && code_decoding_i |=> raw_refused_o)
		else $error("raw read during decoding not refused");
	chk_refuse_cause: assert property (raw_refused_o |-> $past(raw_read_i) && $past(code_decoding_i))
		else $error("refusal without cause");
	chk_tick_single: assert property (pps_o |=> !pps_o)
		else $error("tick longer than one cycle");
	chk_fixed_period: assert property (base && pps_mode_i == 4'h0 |-> gap <= NOMINAL && (!pps_o || gap == NOMINAL))
		else $error("internal second not the fixed length");
	chk_fallback_bound: assert property (base && fallback_internal_i && pps_mode_i != 4'h0 && pps_mode_i != 4'hF
		|-> gap <= NOMINAL + tkpps_pkg::LATE_CYC + 32'h20)
		else $error("no tick after a missing pulse");
	chk_off_silent: assert property ((pps_mode_i == 4'hF) [*3] |-> !pps_o)
		else $error("tick while keeper is off");
	// Main scenarios.
	cov_read: cover property (read_i ##1 rd_valid_o);
	cov_refused: cover property (raw_refused_o);
	cov_ext_tick: cover property (pps_mode_i == 4'h3 && pps_o);
endmodule // tkpps_keeper_assertions

// [bench/tkpps_keeper_tb_top.sv]
// Self-checking bench for the pulse-disciplined time keeper.
module tkpps_keeper_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// A second shortened to 1000 cycles keeps the run brief.
	localparam logic [31:0] NOMINAL = 32'h000003E8;
	localparam int SEC = 1000;
	localparam int LATE = int'(tkpps_pkg::LATE_CYC);
	localparam int GEN = tkpps_pkg::ST_PULSE_GENERATED;
	// Clock, reset and the source model's control and outputs.
	logic clk_i, sys_rst_i, ext_run, ext_p, code_p;
	// Configuration.
	logic [3:0] pps_mode_i;
	logic [1:0] pps_line_i;
	logic fallback_internal_i, use_fixed_period_i, slow_timebase_i, use_binary_seconds_i;
	logic ignore_code_seconds_i, ignore_code_minutes_i, ignore_code_days_i;
	logic signed [5:0] offset_hours_i;
	logic signed [6:0] offset_minutes_i;
	logic [15:0] prop_delay_i;
	// Decoder side.
	logic code_valid_i, code_decoding_i, code_bcd_err_i, code_bin_err_i;
	logic [16:0] code_sbs_i, set_secs_i, rd_secs_o;
	logic [5:0] code_sec_i, code_min_i;
	logic [4:0] code_hour_i;
	logic [8:0] code_yday_i, set_yday_i, rd_yday_o;
	logic [11:0] code_year_i, set_year_i, rd_year_o;
	// Time write and read.
	logic set_i, set_secs_valid_i, set_yday_valid_i, set_year_valid_i, read_i, raw_read_i;
	logic [19:0] rd_us_o;
	logic [tkpps_pkg::ST_WIDTH-1:0] rd_status_o;
	logic rd_valid_o, raw_refused_o, pps_o;
	// Of the ttl and sync lines, only ttl line 2 and sync line 1 carry the source, so a wrong line choice shows.
	wire logic [3:0] ttl_pps_i = {1'b0, ext_p, 2'b00};
	wire logic [3:0] sync_pps_i = {2'b00, ext_p, 1'b0};
	wire logic sat_pps_i = ext_p;
	wire logic rf_pps_i = ext_p;
	wire logic code_pps_i = code_p;
	int error_cnt = 0;
	int check_count = 0;
	tkpps_keeper #(.NOMINAL(NOMINAL)) i_dut (.clk_i, .sys_rst_i, .sat_pps_i, .ttl_pps_i, .rf_pps_i, .sync_pps_i,
		.pps_mode_i, .pps_line_i, .fallback_internal_i, .use_fixed_period_i, .slow_timebase_i, .use_binary_seconds_i,
		.ignore_code_seconds_i, .ignore_code_minutes_i, .ignore_code_days_i, .offset_hours_i, .offset_minutes_i,
		.prop_delay_i, .code_valid_i, .code_pps_i, .code_decoding_i, .code_sbs_i, .code_sec_i, .code_min_i,
		.code_hour_i, .code_yday_i, .code_year_i, .code_bcd_err_i, .code_bin_err_i, .set_i, .set_secs_valid_i,
		.set_yday_valid_i, .set_year_valid_i, .set_secs_i, .set_yday_i, .set_year_i, .read_i, .raw_read_i,
		.rd_secs_o, .rd_us_o, .rd_yday_o, .rd_year_o, .rd_status_o, .rd_valid_o, .raw_refused_o, .pps_o);
	tkpps_pulse_src #(.PERIOD(SEC)) i_src (.clk_i, .run_i(ext_run), .pulse_o(ext_p), .strobe_o(code_p));
	// Free-running 100 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Counts and reports one comparison.
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic chk_time(input logic [16:0] s, input logic [8:0] d, input logic [11:0] y);
		check("rd_secs_o", 32'(s), 32'(rd_secs_o));
		check("rd_yday_o", 32'(d), 32'(rd_yday_o));
		check("rd_year_o", 32'(y), 32'(rd_year_o));
	endtask
	// Ends the run with the verdict.
	task automatic report_and_stop();
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// One read; the answer is looked at in the single cycle that it is flagged.
	task automatic do_read();
		@(posedge clk_i) read_i <= 1'b1;
		@(posedge clk_i) read_i <= 1'b0;
		#1 check("rd_valid_o", 1, 32'(rd_valid_o));
	endtask
	task automatic do_set(input logic [2:0] v, input logic [16:0] s, input logic [8:0] d, input logic [11:0] y);
		@(posedge clk_i) begin
			set_i <= 1'b1;
			{set_year_valid_i, set_yday_valid_i, set_secs_valid_i} <= v;
			{set_secs_i, set_yday_i, set_year_i} <= {s, d, y};
		end
		@(posedge clk_i) set_i <= 1'b0;
	endtask
	// Waits, bounded, for a tick and returns the cycles waited.
	task automatic wait_pps(input int max, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (pps_o !== 1'b1 && n < max);
		check("pps_o", 1, 32'(pps_o));
	endtask
	task automatic send_code();
		@(posedge clk_i) code_valid_i <= 1'b1;
		@(posedge clk_i) code_valid_i <= 1'b0;
	endtask
	task automatic t_parts();
		int n;
		do_read();
		chk_time(17'h00000, 9'h001, 12'h7D0);
		wait_pps(SEC + 10, n);
		do_set(3'h7, 17'h00064, 9'h032, 12'h7DA);
		do_set(3'h1, 17'h000C8, 9'h007, 12'h007);
		do_set(3'h2, 17'h00007, 9'h0AA, 12'h007);
		do_set(3'h4, 17'h00007, 9'h007, 12'h7E0);
		do_read();
		chk_time(17'h000C8, 9'h0AA, 12'h7E0);
	endtask
	task automatic t_tick();
		int n;
		wait_pps(SEC + 10, n);
		do_set(3'h1, 17'h001F4, 9'h000, 12'h000);
		do_read();
		wait_pps(SEC + 10, n);
		do_read();
		check("rd_secs_o", 32'h1F5, 32'(rd_secs_o));
		check("rd_us_o", 0, 32'(rd_us_o));
		check("generated", 1, 32'(rd_status_o[GEN]));
		do_read();
		check("generated", 0, 32'(rd_status_o[GEN]));
	endtask
	task automatic t_roll();
		logic [11:0] yr [3] = '{12'h7D1, 12'h7D0, 12'h7D0};
		logic [8:0] dy [3] = '{9'h16D, 9'h16D, 9'h00A};
		logic [11:0] ey [3] = '{12'h7D2, 12'h7D0, 12'h7D0};
		logic [8:0] ed [3] = '{9'h001, 9'h16E, 9'h00B};
		int n;
		for (int i = 0; i < 3; i++) begin
			wait_pps(SEC + 10, n);
			do_set(3'h7, 17'h1517F, dy[i], yr[i]);
			wait_pps(SEC + 10, n);
			do_read();
			chk_time(17'h00000, ed[i], ey[i]);
		end
	endtask
	task automatic t_offset();
		int n;
		wait_pps(SEC + 10, n);
		@(posedge clk_i) offset_hours_i <= 6'sd1;
		do_set(3'h7, 17'h01C20, 9'h020, 12'h7D5);
		@(posedge clk_i) offset_hours_i <= 6'sd0;
		do_read();
		check("rd_secs_o", 32'h0E10, 32'(rd_secs_o));
	endtask
	task automatic t_code();
		do_read();
		send_code();
		do_read();
		check("code ignored", 0, 32'(rd_status_o & 10'h024));
		@(posedge clk_i) pps_mode_i <= 4'h1;
		send_code();
		do_read();
		check("code flags", 32'h27, 32'(rd_status_o & 10'h027));
		do_read();
		check("code flags", 0, 32'(rd_status_o & 10'h027));
		@(posedge clk_i) {use_binary_seconds_i, ignore_code_seconds_i, ignore_code_minutes_i, ignore_code_days_i,
			code_yday_i} <= {4'hF, 9'h0FF};
		send_code();
		do_read();
		check("applied", 32'h20, 32'(rd_status_o & 10'h020));
		check("kept yday", 32'h00A, 32'(rd_yday_o));
	endtask
	task automatic t_raw();
		@(posedge clk_i) raw_read_i <= 1'b1;
		@(posedge clk_i) raw_read_i <= 1'b0;
		#1 check("raw year", 32'h7E1, 32'(rd_year_o));
		check("raw yday", 32'h0FF, 32'(rd_yday_o));
		@(posedge clk_i) {code_decoding_i, raw_read_i} <= 2'h3;
		@(posedge clk_i) {code_decoding_i, raw_read_i} <= 2'h0;
		#1 check("raw_refused_o", 1, 32'(raw_refused_o));
	endtask
	// Each external source in turn, then loss of the source, then the keeper switched off.
	task automatic t_ext();
		int n;
		@(posedge clk_i) {ext_run, fallback_internal_i, prop_delay_i} <= {1'b1, 1'b0, 16'h0003};
		for (int m = 1; m < 6; m++) begin
			@(posedge clk_i) {pps_mode_i, pps_line_i} <= {4'(m), (m == 3) ? 2'h2 : 2'h1};
			repeat (2 * SEC) @(posedge clk_i);
			do_read();
			repeat (SEC + 10) @(posedge clk_i);
			do_read();
			check("received", 1, 32'(rd_status_o[tkpps_pkg::ST_PULSE_RECEIVED]));
		end
		@(posedge clk_i) {fallback_internal_i, pps_mode_i, pps_line_i} <= {1'b1, 4'h3, 2'h2};
		repeat (2 * SEC) @(posedge clk_i);
		wait_pps(SEC + 10, n);
		@(posedge clk_i) ext_run <= 1'b0;
		wait_pps(SEC + LATE + 100, n);
		check("late tick", 1, 32'(n >= SEC + LATE));
		do_read();
		check("lost", 1, 32'(rd_status_o[tkpps_pkg::ST_PULSE_LOST]));
		@(posedge clk_i) pps_mode_i <= 4'hF;
		do_read();
		repeat (2 * SEC) @(posedge clk_i);
		do_read();
		check("generated", 0, 32'(rd_status_o[GEN]));
	endtask
	// Cuts a hang short well beyond the expected length of the run.
	initial begin
		repeat (90000) @(posedge clk_i);
		error_cnt++;
		report_and_stop();
	end
	// Values at time zero, reset, then the scenarios.
	initial begin
		{sys_rst_i, ext_run, read_i, raw_read_i, set_i, code_valid_i, code_decoding_i} = 7'h40;
		{pps_mode_i, pps_line_i, slow_timebase_i, use_binary_seconds_i} = 8'h00;
		{ignore_code_seconds_i, ignore_code_minutes_i, ignore_code_days_i} = 3'h0;
		{fallback_internal_i, use_fixed_period_i, code_bcd_err_i, code_bin_err_i} = 4'hF;
		{offset_hours_i, offset_minutes_i, prop_delay_i} = '0;
		{set_secs_valid_i, set_yday_valid_i, set_year_valid_i, set_secs_i, set_yday_i, set_year_i} = '0;
		{code_sbs_i, code_hour_i, code_min_i, code_sec_i} = {17'h047BF, 5'h05, 6'h06, 6'h07};
		{code_yday_i, code_year_i} = {9'h00A, 12'h7E1};
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_parts();
		t_tick();
		t_roll();
		t_offset();
		t_code();
		t_raw();
		t_ext();
		report_and_stop();
	end
endmodule // tkpps_keeper_tb_top

bind tkpps_keeper tkpps_keeper_assertions #(.NOMINAL(NOMINAL)) i_chk (.clk_i, .sys_rst_i, .pps_mode_i,
	.fallback_internal_i, .use_fixed_period_i, .set_i, .read_i, .raw_read_i, .code_decoding_i, .rd_secs_o,
	.rd_year_o, .rd_valid_o, .raw_refused_o, .pps_o);
